// ### rtl/dsp_digital_io.sv
// 24-line digital i/o with scan capture, pattern output and analog trigger
// assumes pins and scan strobes synchronous to core_clk; the comparator
// input is an already digitised first-channel sample
`timescale 1ns/1ns
`default_nettype none
module dsp_digital_io (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  // pins
  input wire logic [23:0] pinIn,
  output logic [23:0] pinOut,
  output logic [23:0] pinOe,
  // host direct access
  input wire logic [2:0] dirOut,
  input wire logic [2:0] outWrEn,
  input wire logic [23:0] outWrData,
  output logic [23:0] hostRdData,
  // scan sequencer
  input wire logic scanStart,
  input wire logic convSlot,
  input wire logic scanHasAnalog,
  input wire logic digRateTick,
  input wire dsp_pkg::dsp_smp_mode_t smpMode,
  output dsp_pkg::dsp_sample_t scanSample,
  output logic scanValid,
  // pattern generation
  input wire logic patRun,
  input wire logic [dsp_pkg::PAT_DIV_W-1:0] patDivide,
  input wire logic [15:0] patData,
  input wire logic patValid,
  output logic patReady,
  // analog trigger
  input wire dsp_pkg::dsp_trig_cfg_t trigCfg,
  input wire logic trigArm,
  input wire logic [15:0] firstChan,
  input wire logic firstChanValid,
  output logic trigFired,
  output dsp_pkg::dsp_trg_state_t trigState
);
  import dsp_pkg::*;

  logic [23:0] outVal_q;
  logic [23:0] rdSync_q;
  logic patTick;
  logic [15:0] patHold_q;
  logic patFull_q;
  logic cmpAbove_q;
  logic cmpValid_q;
  dsp_trg_state_t trg_q;
  logic cmpNow;
  logic [23:0] patWide;

  // group level enable; an input group never drives its pins
  function automatic logic [23:0] grpMask(input logic [2:0] g);
    grpMask = {{8{g[2]}}, {8{g[1]}}, {8{g[0]}}};
  endfunction

  // host output writes, group by group; pattern overrides groups 0 and 1
  // pattern word widened so every group slice stays in range
  assign patWide = {8'h00, patHold_q};
  genvar gi;
  generate
    for (gi = 0; gi < GROUPS; gi++) begin : g_out
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          outVal_q[gi*8 +: 8] <= OUT_RESET;
        end else if (clkEn) begin
          if (gi < 2 && patRun && patTick && patFull_q)
            outVal_q[gi*8 +: 8] <= patWide[gi*8 +: 8];
          else if (outWrEn[gi])
            outVal_q[gi*8 +: 8] <= outWrData[gi*8 +: 8];
        end
      end
    end
  endgenerate

  assign pinOut = outVal_q & grpMask(dirOut);
  assign pinOe = grpMask(dirOut);

  // registered host read path, separate from the scan capture
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      rdSync_q <= '0;
    else if (clkEn)
      rdSync_q <= pinIn;
  end
  assign hostRdData = rdSync_q;

  // scan capture: strobes ride existing slots, never add slots
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scanSample <= '0;
      scanValid <= 1'b0;
    end else if (clkEn) begin
      scanValid <= 1'b0;
      if (scanHasAnalog) begin
        if (scanStart) begin
          scanSample.lines <= pinIn;
          scanSample.perSlot <= 1'b0;
          scanValid <= 1'b1;
        end else if (smpMode == SMP_PER_SLOT && convSlot) begin
          scanSample.lines <= {8'h00, pinIn[15:0]};
          scanSample.perSlot <= 1'b1;
          scanValid <= 1'b1;
        end
        // idle remainder: nothing captured
      end else if (digRateTick) begin
        scanSample.lines <= pinIn;
        scanSample.perSlot <= 1'b0;
        scanValid <= 1'b1;
      end
    end
  end

  dsp_pattern_clk u_pclk (
    .core_clk(core_clk),
    .rst(rst),
    .clkEn(clkEn),
    .run(patRun),
    .divide(patDivide),
    .tick(patTick)
  );

  // one-word holding stage; a new word is taken once the last is shown
  assign patReady = !patFull_q || patTick;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      patHold_q <= '0;
      patFull_q <= 1'b0;
    end else if (clkEn) begin
      if (patValid && patReady) begin
        patHold_q <= patData;
        patFull_q <= 1'b1;
      end else if (patTick) begin
        patFull_q <= 1'b0;
      end
    end
  end

  // comparator with hysteresis band around the programmed level
  always_comb begin
    if (cmpAbove_q)
      cmpNow = 16'(firstChan + trigCfg.hyst) >= trigCfg.level;
    else
      cmpNow = firstChan >= 16'(trigCfg.level + trigCfg.hyst);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmpAbove_q <= 1'b0;
      cmpValid_q <= 1'b0;
    end else if (clkEn) begin
      if (firstChanValid) begin
        cmpAbove_q <= cmpNow;
        cmpValid_q <= 1'b1;
      end else if (trigArm) begin
        // a new arm forgets the old side, so a stale state cannot fire
        cmpValid_q <= 1'b0;
      end
    end
  end

  // arm first records the present side, then waits for a change
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trg_q <= TRG_IDLE;
    end else if (clkEn) begin
      case (trg_q)
        TRG_IDLE: if (trigArm) trg_q <= TRG_PRIME;
        TRG_PRIME: if (cmpValid_q) trg_q <= TRG_WAIT;
        TRG_WAIT: begin
          if (firstChanValid && cmpNow != cmpAbove_q &&
              cmpNow == !trigCfg.falling)
            trg_q <= TRG_FIRED;
        end
        TRG_FIRED: if (trigArm) trg_q <= TRG_PRIME;
        default: trg_q <= TRG_IDLE;
      endcase
    end
  end
  assign trigFired = (trg_q == TRG_FIRED);
  assign trigState = trg_q;

  inputNoDrive_a: assert property (@(posedge core_clk) disable iff (rst)
    (pinOe & ~grpMask(dirOut)) == 24'h0 && (pinOut & ~pinOe) == 24'h0)
    else $error("input group drives pins");
  hostWrite_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && outWrEn[2] |=> outVal_q[23:16] == $past(outWrData[23:16]))
    else $error("host write to group 2 lost");
  hostRead_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn |=> hostRdData == $past(pinIn))
    else $error("host read not current");
  startCap_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && scanHasAnalog && scanStart |=>
      scanValid && scanSample.lines == $past(pinIn))
    else $error("start of scan capture missing");
  slotCap_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && scanHasAnalog && !scanStart && convSlot &&
      smpMode == SMP_PER_SLOT |=> scanValid && scanSample.perSlot)
    else $error("per slot capture missing");
  idleQuiet_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && scanHasAnalog && !scanStart && !convSlot |=> !scanValid)
    else $error("capture in idle time");
  digOnly_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && !scanHasAnalog && digRateTick |=> scanValid)
    else $error("digital only sample lost");
  sequence armSeen_s;
    clkEn && trigArm && trg_q == TRG_IDLE;
  endsequence
  armNoFire_a: assert property (@(posedge core_clk) disable iff (rst)
    armSeen_s |=> !trigFired ##1 !trigFired)
    else $error("trigger fired without fresh edge");
  freshArm_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && trigArm && !firstChanValid &&
      (trg_q == TRG_IDLE || trg_q == TRG_FIRED) |=>
      trg_q == TRG_PRIME && !cmpValid_q)
    else $error("arm kept an old comparator side");
  waitNoFire_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && trg_q == TRG_WAIT && !firstChanValid |=> !trigFired)
    else $error("trigger fired without a sample");
  patApply_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && patRun && patTick && patFull_q |=>
      outVal_q[15:0] == $past(patHold_q))
    else $error("pattern word not applied");
endmodule
`default_nettype wire

// ### rtl/dsp_pkg.sv
// package for the digital i/o, scan capture, pattern and trigger block
// assumes one 100 MHz core clock shared by every file of the block
package dsp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int GROUPS = 3;
  localparam int LINES = 24;
  // pacing divider bounds: one update per second down to 1 MHz
  localparam int PAT_SLOW_S = 1;
  localparam int PAT_FAST_MHZ = 1;
  localparam int PAT_MIN_DIV = CLK_MHZ / PAT_FAST_MHZ;
  localparam int PAT_MAX_DIV = PAT_SLOW_S * CLK_MHZ * 1000000;
  localparam int PAT_DIV_W = 27;
  // trigger latency bound in ns and the cycles it allows
  localparam int TRIG_LAT_NS = 1000;
  localparam int TRIG_LAT_CYC = TRIG_LAT_NS * CLK_MHZ / 1000;
  localparam logic [1:0] DIR_RESET = 2'h0;
  localparam logic [15:0] THR_RESET = 16'h0;
  localparam logic [7:0] OUT_RESET = 8'h0;

  typedef enum logic [1:0] {
    TRG_IDLE = 2'b00,
    TRG_PRIME = 2'b01,
    TRG_WAIT = 2'b10,
    TRG_FIRED = 2'b11
  } dsp_trg_state_t;

  typedef enum logic {
    SMP_PER_SCAN = 1'b0,
    SMP_PER_SLOT = 1'b1
  } dsp_smp_mode_t;

  // one captured scan word set
  typedef struct packed {
    logic [23:0] lines;
    logic perSlot;
  } dsp_sample_t;

  // analog trigger settings
  typedef struct packed {
    logic [15:0] level;
    logic [15:0] hyst;
    logic falling;
  } dsp_trig_cfg_t;
endpackage

// ### rtl/dsp_pattern_clk.sv
// programmable pacing divider for pattern output
// assumes divide value stays stable while running
`timescale 1ns/1ns
`default_nettype none
module dsp_pattern_clk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  // control
  input wire logic run,
  input wire logic [dsp_pkg::PAT_DIV_W-1:0] divide,
  // pacing pulse
  output logic tick
);
  import dsp_pkg::*;
  logic [PAT_DIV_W-1:0] cnt_q;
  logic [PAT_DIV_W-1:0] lim;

  // clamp into the 1 MHz .. 1 Hz window
  always_comb begin
    if (divide < PAT_DIV_W'(PAT_MIN_DIV))
      lim = PAT_DIV_W'(PAT_MIN_DIV);
    else if (divide > PAT_DIV_W'(PAT_MAX_DIV))
      lim = PAT_DIV_W'(PAT_MAX_DIV);
    else
      lim = divide;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (clkEn) begin
      tick <= 1'b0;
      if (!run) begin
        cnt_q <= '0;
      end else if (cnt_q >= lim - 1'b1) begin
        cnt_q <= '0;
        tick <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  tickSpacing_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && tick |=> !tick)
    else $error("pattern ticks back to back");
endmodule
`default_nettype wire

// ### dv/dsp_line_model.sv
// far-side model of the 24 external ttl lines
// assumes the bench supplies what outside drivers put on the lines
`timescale 1ns/1ns
`default_nettype none
module dsp_line_model (
  // pins
  input wire logic [23:0] pinOut,
  input wire logic [23:0] pinOe,
  input wire logic [23:0] extDrive,
  output logic [23:0] pinIn
);
  // outside drivers only win where the device keeps its drivers off
  assign pinIn = (pinOe & pinOut) | (~pinOe & extDrive);
endmodule
`default_nettype wire

// ### dv/dsp_digital_io_tb.sv
// self-checking bench for the digital i/o block
// assumes dsp_line_model resolves the pins and a 100 MHz core clock
`timescale 1ns/1ns
`default_nettype none
module dsp_digital_io_tb;
  import dsp_pkg::*;
  logic core_clk, rst, clkEn, scanStart, convSlot, scanHasAnalog;
  logic digRateTick, patRun, patValid, patReady, trigArm, firstChanValid;
  logic trigFired, scanValid;
  logic [2:0] dirOut, outWrEn, d;
  logic [23:0] outWrData, extDrive, pinIn, pinOut, pinOe, hostRdData, p, w;
  logic [PAT_DIV_W-1:0] patDivide;
  logic [15:0] patData, firstChan, hi, lo, bd;
  dsp_smp_mode_t smpMode;
  dsp_sample_t scanSample;
  dsp_trig_cfg_t trigCfg;
  dsp_trg_state_t trigState;
  int err_total, comparisons, n, c0;
  int cyc = 0;

  dsp_digital_io dsp_digital_io_inst (.core_clk, .rst, .clkEn, .pinIn,
    .pinOut, .pinOe, .dirOut, .outWrEn, .outWrData, .hostRdData,
    .scanStart, .convSlot, .scanHasAnalog, .digRateTick, .smpMode,
    .scanSample, .scanValid, .patRun, .patDivide, .patData, .patValid,
    .patReady, .trigCfg, .trigArm, .firstChan, .firstChanValid,
    .trigFired, .trigState);
  dsp_line_model dsp_line_model_inst (.pinOut, .pinOe, .extDrive, .pinIn);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (++cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("errors=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk24(input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // strobes are {scanStart, convSlot, digRateTick}
  task automatic scan(input logic [2:0] s, input logic v,
                      input logic [23:0] e);
    @(posedge core_clk);
    {scanStart, convSlot, digRateTick} <= s;
    @(posedge core_clk);
    {scanStart, convSlot, digRateTick} <= 3'h0;
    @(negedge core_clk);
    chk24({23'h0, v}, {23'h0, scanValid});
    if (v) chk24(e, scanSample.lines);
    if (v) chk24({23'h0, s == 3'h2}, {23'h0, scanSample.perSlot});
  endtask
  task automatic send(input logic [15:0] v);
    @(posedge core_clk);
    patData <= v;
    patValid <= 1'b1;
    n = 0;
    do @(negedge core_clk); while (patReady !== 1'b1 && ++n < 300);
    @(posedge core_clk);
    patValid <= 1'b0;
  endtask
  task automatic waitpat(input logic [15:0] v);
    n = 0;
    do @(negedge core_clk); while (pinOut[15:0] !== v && ++n < 300);
    chk24({8'h0, v}, {8'h0, pinOut[15:0]});
  endtask
  // the sample stands for the first channel of the scan
  task automatic smp(input logic [15:0] v, input logic e);
    @(posedge core_clk);
    firstChan <= v;
    firstChanValid <= 1'b1;
    @(posedge core_clk);
    firstChanValid <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk24({23'h0, e}, {23'h0, trigFired});
    chk24({22'h0, e ? TRG_FIRED : TRG_WAIT}, {22'h0, trigState});
  endtask

  initial begin
    {rst, clkEn, scanStart, convSlot, scanHasAnalog} = 5'h19;
    {digRateTick, patRun, patValid, trigArm, firstChanValid} = 5'h0;
    {dirOut, outWrEn, outWrData, extDrive} = '0;
    {patData, firstChan, trigCfg} = '0;
    patDivide = 27'h64;
    smpMode = SMP_PER_SCAN;
    {err_total, comparisons} = 64'h0;
    n = $urandom(32'h5e925eb1);
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($urandom);
      w = 24'($urandom);
      p = {{8{d[2]}}, {8{d[1]}}, {8{d[0]}}};
      @(posedge core_clk);
      dirOut <= d;
      // output groups are always rewritten, input groups only at random
      outWrEn <= 3'($urandom) | d;
      outWrData <= w;
      extDrive <= ~w;
      @(posedge core_clk);
      outWrEn <= 3'h0;
      @(negedge core_clk);
      chk24(w & p, pinOut);
      chk24(p, pinOe);
      p = pinIn;
      @(negedge core_clk);
      chk24(p, hostRdData);
    end
    // with the clock enable low a host write must not land
    @(negedge core_clk);
    p = pinOut;
    @(posedge core_clk);
    clkEn <= 1'b0;
    outWrEn <= 3'h7;
    outWrData <= ~p;
    @(posedge core_clk);
    clkEn <= 1'b1;
    outWrEn <= 3'h0;
    @(negedge core_clk);
    chk24(p, pinOut);
    w = 24'($urandom);
    @(posedge core_clk);
    dirOut <= 3'h0;
    extDrive <= w;
    scan(3'h4, 1'b1, w);
    scan(3'h2, 1'b0, w);
    scan(3'h1, 1'b0, w);
    @(posedge core_clk) smpMode <= SMP_PER_SLOT;
    scan(3'h2, 1'b1, {8'h0, w[15:0]});
    scan(3'h6, 1'b1, w);
    scan(3'h0, 1'b0, w);
    chk24(w, hostRdData);
    @(posedge core_clk) scanHasAnalog <= 1'b0;
    scan(3'h1, 1'b1, w);
    @(posedge core_clk);
    dirOut <= 3'h3;
    patRun <= 1'b1;
    @(negedge core_clk);
    p = ~pinOut;
    send(p[15:0]);
    waitpat(p[15:0]);
    c0 = cyc;
    send(~p[15:0]);
    waitpat(~p[15:0]);
    chk24(24'h64, 24'(cyc - c0));
    for (int f = 0; f < 2; f++) begin
      hi = f ? 16'h0064 : 16'h07d0;
      lo = f ? 16'h07d0 : 16'h0064;
      bd = f ? 16'h03f0 : 16'h03e0;
      @(posedge core_clk);
      trigCfg <= '{16'h03e8, 16'h0010, f[0]};
      trigArm <= 1'b1;
      @(posedge core_clk);
      trigArm <= 1'b0;
      smp(hi, 1'b0);
      smp(hi, 1'b0);
      smp(bd, 1'b0);
      smp(hi, 1'b0);
      smp(lo, 1'b0);
      smp(hi, 1'b1);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
